//--- hw/uas_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef UAS_CFG_SVH
`define UAS_CFG_SVH

// ==========================================================
// Register offsets (word index on the register port)
`define UAS_OFF_STA 4'h0
`define UAS_OFF_MODE 4'h1
`define UAS_OFF_BRG 4'h2
`define UAS_OFF_TXD 4'h3
`define UAS_OFF_RXD 4'h4

// ==========================================================
// Field positions of the status and control register
`define UAS_B_TXISEL1 15
`define UAS_B_TXINV 14
`define UAS_B_TXISEL0 13
`define UAS_B_BRK 11
`define UAS_B_TXEN 10
`define UAS_B_TXBF 9
`define UAS_B_TX_ALL_EMPTY_FLAG 8
`define UAS_B_RXISEL1 7
`define UAS_B_RXISEL0 6
`define UAS_B_ADDRESS_DETECT_ON 5
`define UAS_B_RX_LINE_IDLE_FLAG 4
`define UAS_B_PARITY_ERROR_FLAG 3
`define UAS_B_FRAMING_ERROR_FLAG 2
`define UAS_B_OVERRUN_ERROR_FLAG 1
`define UAS_B_RX_DATA_AVAILABLE_FLAG 0

// ==========================================================
// Reset values
`define UAS_BRG_RST 16'h0000
`define UAS_MODE_RST 8'h00

// ==========================================================
// Timing counts: ticks of the 16x baud clock, break bits, sync falls; then buffer depth
`define UAS_TICK_LAST 4'hF
`define UAS_TICK_MID 4'h7
`define UAS_IR_PULSE 4'h3
`define UAS_BRK_BITS 4'hC
`define UAS_AB_FALLS 3'h4
`define UAS_FIFO_DEPTH 3'h4

`endif

//--- hw/uas_pkg.sv
// Types shared by the serial port modules
package uas_pkg;

  // Bit phase of a frame, Gray coded along the usual path
  typedef enum logic [2:0] {
    UAS_IDLE = 3'h0,
    UAS_START = 3'h1,
    UAS_DATA = 3'h3,
    UAS_PAR = 3'h2,
    UAS_STOP1 = 3'h6,
    UAS_STOP2 = 3'h7
  } uas_bit_e;

  // One received character with its error marks
  typedef struct packed {
    logic framing_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } uas_rx_word_s;

  // Writable fields of the status and control register
  typedef struct packed {
    logic [1:0] txisel;
    logic txinv;
    logic brk;
    logic txen;
    logic [1:0] rxisel;
    logic address_detect_on;
    logic overrun_error_flag;
  } uas_sta_s;

  // Mode register, bit 0 first from the right
  typedef struct packed {
    logic infrared_coding_on;
    logic abaud;
    logic flow;
    logic loop;
    logic stop2;
    logic par_odd;
    logic par_en;
    logic nine;
  } uas_mode_s;

  // Whole state of the port
  typedef struct packed {
    uas_sta_s sta;
    uas_mode_s mode;
    logic [15:0] brg;
    uas_bit_e tstate;
    logic [8:0] tsh;
    logic [3:0] tcnt;
    logic [3:0] tbit;
    logic tbrk;
    logic tpar;
    logic traw;
    uas_bit_e rstate;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    logic [3:0] rbit;
    logic rperr;
    logic rprev;
    logic [19:0] abcnt;
    logic [2:0] abfall;
    logic [15:0] rdata;
    logic txo;
    logic txoe_n;
    logic rts_n;
    logic txirq;
    logic rxirq;
    logic bclk;
  } uas_main_s;

endpackage

//--- hw/uas_fifo.sv
// Four-deep first-in first-out character buffer
`timescale 1ns/100ps
`default_nettype none
`include "uas_cfg.svh"
module uas_fifo #(
  parameter int W = 11
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic full,
  output logic empty,
  output logic [2:0] count
);
  typedef struct packed {
    logic [3:0][W-1:0] mem;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
  } uas_fifo_s;
  uas_fifo_s q, d;
  logic do_push, do_pop;

  // Status seen by both sides
  assign full = (q.cnt == `UAS_FIFO_DEPTH);
  assign empty = (q.cnt == 3'h0);
  assign count = q.cnt;
  assign rdata = q.mem[q.rp];

  // Next state; full refuses a push, empty refuses a pop
  always_comb begin
    d = q;
    do_push = push && !full;
    do_pop = pop && !empty;
    if (do_push) begin
      d.mem[q.wp] = wdata;
      d.wp = q.wp + 2'h1;
    end
    if (do_pop) begin
      d.rp = q.rp + 2'h1;
    end
    d.cnt = q.cnt + {2'h0, do_push} - {2'h0, do_pop};
    if (flush) begin
      d.wp = 2'h0;
      d.rp = 2'h0;
      d.cnt = 3'h0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- hw/uas_baud.sv
// Baud prescaler giving one tick per sixteenth of a bit and the 16x clock
`timescale 1ns/100ps
`default_nettype none
module uas_baud (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] brg,
  output logic tick,
  output logic clk16
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
    logic clk16;
  } uas_baud_s;
  uas_baud_s q, d;

  assign tick = q.tick;
  assign clk16 = q.clk16;

  // Count brg+1 system clocks per tick; high for the first half of each period
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt >= brg) begin
      d.cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
    d.clk16 = (d.cnt <= {1'b0, brg[15:1]});
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- hw/uas_serial_port.sv
// Full-duplex asynchronous serial port with status, buffers and baud generator
// Function
// - Full duplex, eight or nine data bits
// - Eight-bit frames: even, odd or no parity
// - One or two stop bits per frame
// - Bit timing from sixteen-bit baud prescaler
// - Transmit buffer holds four characters
// - Receive buffer holds four characters
// - Report parity, framing and overrun errors
// - Ninth bit one marks address character
// - Loopback routes transmit back to receiver
// - Measure sync character, set baud automatically
// - Output clock at sixteen times baud
// - Clear-to-send and request-to-send pace transfers
// - Transmit interrupt select: load, done, empty
// - Polarity bit sets transmit idle level
// - Break: start, twelve zeros, stop, self-clearing
// - Transmit enable owns pin; clearing aborts
// - Buffer full flag at bit nine
// - All-empty flag at bit eight
// - Receive interrupt at one, three or four
`timescale 1ns/100ps
`default_nettype none
`include "uas_cfg.svh"
module uas_serial_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var logic [15:0] reg_rdata,
  output var logic serial_tx_pin,
  output var logic serial_tx_oe_n,
  input wire logic serial_rx_pin,
  input wire logic clear_to_send_in_n,
  output var logic request_to_send_out_n,
  output var logic baud_x16_clk,
  output var logic tx_irq,
  output var logic rx_irq
);
  import uas_pkg::*;

  // ==========================================================
  // Declarations
  uas_main_s q, d;
  logic tick, clk16;
  logic tf_push, tf_pop, tf_full, tf_empty;
  logic [2:0] tf_cnt, rf_cnt;
  logic [8:0] tf_head;
  logic rf_push, rf_pop, rf_full, rf_empty;
  uas_rx_word_s rf_in, rf_head;
  logic rx_line, t_end, r_end, r_mid;
  logic [3:0] tx_nbits, rx_nbits;
  logic [8:0] rx_word;
  logic ir_pulse;

  localparam uas_main_s UAS_MAIN_RST = '{
    mode: `UAS_MODE_RST,
    brg: `UAS_BRG_RST,
    tstate: UAS_IDLE,
    rstate: UAS_IDLE,
    traw: 1'b1,
    rprev: 1'b1,
    txo: 1'b1,
    txoe_n: 1'b1,
    default: '0
  };

  // Parity bit for eight data bits, even or odd
  function automatic logic par_of(input logic [7:0] v, input logic odd);
    par_of = (^v) ^ odd;
  endfunction

  // ==========================================================
  // Buffers and baud generator
  uas_fifo #(.W(9)) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(!q.sta.txen),
    .push(tf_push),
    .wdata(reg_wdata[8:0]),
    .pop(tf_pop),
    .rdata(tf_head),
    .full(tf_full),
    .empty(tf_empty),
    .count(tf_cnt)
  );

  uas_fifo #(.W(11)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(1'b0),
    .push(rf_push),
    .wdata(rf_in),
    .pop(rf_pop),
    .rdata(rf_head),
    .full(rf_full),
    .empty(rf_empty),
    .count(rf_cnt)
  );

  uas_baud u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .brg(q.brg),
    .tick(tick),
    .clk16(clk16)
  );

  // Receiver input, internal transmit line in loopback
  assign rx_line = q.mode.loop ? q.traw : serial_rx_pin;
  assign t_end = tick && (q.tcnt == `UAS_TICK_LAST);
  assign r_end = tick && (q.rcnt == `UAS_TICK_LAST);
  assign r_mid = tick && (q.rcnt == `UAS_TICK_MID);
  assign tx_nbits = q.tbrk ? `UAS_BRK_BITS : (q.mode.nine ? 4'h9 : 4'h8);
  assign rx_nbits = q.mode.nine ? 4'h9 : 4'h8;
  assign rx_word = q.mode.nine ? q.rsh : {1'b0, q.rsh[8:1]};

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    d.txirq = 1'b0;
    d.rxirq = 1'b0;
    d.bclk = clk16;
    tf_push = 1'b0;
    tf_pop = 1'b0;
    rf_push = 1'b0;
    rf_pop = 1'b0;
    rf_in = '{framing_error_flag: ~rx_line, parity_error_flag: q.rperr, data: rx_word};
    ir_pulse = 1'b0;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == `UAS_OFF_STA) begin
        d.sta.txisel = {reg_wdata[`UAS_B_TXISEL1], reg_wdata[`UAS_B_TXISEL0]};
        d.sta.txinv = reg_wdata[`UAS_B_TXINV];
        d.sta.brk = reg_wdata[`UAS_B_BRK];
        d.sta.txen = reg_wdata[`UAS_B_TXEN];
        d.sta.rxisel = {reg_wdata[`UAS_B_RXISEL1], reg_wdata[`UAS_B_RXISEL0]};
        d.sta.address_detect_on = reg_wdata[`UAS_B_ADDRESS_DETECT_ON];
        if (!reg_wdata[`UAS_B_OVERRUN_ERROR_FLAG]) begin
          d.sta.overrun_error_flag = 1'b0;
        end
      end else if (reg_addr == `UAS_OFF_MODE) begin
        d.mode = reg_wdata[7:0];
      end else if (reg_addr == `UAS_OFF_BRG) begin
        d.brg = reg_wdata;
      end else if (reg_addr == `UAS_OFF_TXD) begin
        tf_push = q.sta.txen;
      end
    end

    // Register reads, data stand one cycle later
    if (reg_rd) begin
      if (reg_addr == `UAS_OFF_STA) begin
        d.rdata[`UAS_B_TXISEL1] = q.sta.txisel[1];
        d.rdata[`UAS_B_TXINV] = q.sta.txinv;
        d.rdata[`UAS_B_TXISEL0] = q.sta.txisel[0];
        d.rdata[`UAS_B_BRK] = q.sta.brk;
        d.rdata[`UAS_B_TXEN] = q.sta.txen;
        d.rdata[`UAS_B_TXBF] = tf_full;
        d.rdata[`UAS_B_TX_ALL_EMPTY_FLAG] = (q.tstate == UAS_IDLE) && tf_empty;
        d.rdata[7:6] = q.sta.rxisel;
        d.rdata[`UAS_B_ADDRESS_DETECT_ON] = q.sta.address_detect_on;
        d.rdata[`UAS_B_RX_LINE_IDLE_FLAG] = (q.rstate == UAS_IDLE);
        d.rdata[`UAS_B_PARITY_ERROR_FLAG] = !rf_empty && rf_head.parity_error_flag;
        d.rdata[`UAS_B_FRAMING_ERROR_FLAG] = !rf_empty && rf_head.framing_error_flag;
        d.rdata[`UAS_B_OVERRUN_ERROR_FLAG] = q.sta.overrun_error_flag;
        d.rdata[`UAS_B_RX_DATA_AVAILABLE_FLAG] = !rf_empty;
      end else if (reg_addr == `UAS_OFF_MODE) begin
        d.rdata = {8'h00, q.mode};
      end else if (reg_addr == `UAS_OFF_BRG) begin
        d.rdata = q.brg;
      end else if (reg_addr == `UAS_OFF_RXD) begin
        d.rdata = {7'h00, rf_head.data};
        rf_pop = 1'b1;
      end
    end

    // Transmitter frame sequence
    if (tick) begin
      d.tcnt = q.tcnt + 4'h1;
    end
    case (q.tstate)
      UAS_IDLE: begin
        d.tcnt = 4'h0;
        // Start only on a tick, and only with clear-to-send when pacing is on
        if (q.sta.txen && tick && (!q.mode.flow || !clear_to_send_in_n)) begin
          if (q.sta.brk) begin
            d.tbrk = 1'b1;
            d.tsh = 9'h000;
            d.tstate = UAS_START;
          end else if (!tf_empty) begin
            tf_pop = 1'b1;
            d.tsh = tf_head;
            d.tpar = par_of(tf_head[7:0], q.mode.par_odd);
            d.tstate = UAS_START;
            if (q.sta.txisel == 2'h0 || (q.sta.txisel == 2'h2 && tf_cnt == 3'h1)) begin
              d.txirq = 1'b1;
            end
          end
        end
      end
      UAS_START: begin
        if (t_end) begin
          d.tstate = UAS_DATA;
          d.tbit = 4'h0;
        end
      end
      UAS_DATA: begin
        if (t_end) begin
          d.tsh = {1'b0, q.tsh[8:1]};
          d.tbit = q.tbit + 4'h1;
          if (q.tbit == tx_nbits - 4'h1) begin
            d.tstate = (q.mode.par_en && !q.mode.nine && !q.tbrk) ? UAS_PAR : UAS_STOP1;
          end
        end
      end
      UAS_PAR: begin
        if (t_end) begin
          d.tstate = UAS_STOP1;
        end
      end
      UAS_STOP1, UAS_STOP2: begin
        if (t_end) begin
          if (q.tstate == UAS_STOP1 && q.mode.stop2) begin
            d.tstate = UAS_STOP2;
          end else begin
            d.tstate = UAS_IDLE;
            if (q.tbrk) begin
              d.tbrk = 1'b0;
              d.sta.brk = 1'b0;
            end
            if (q.sta.txisel == 2'h1 && tf_empty) begin
              d.txirq = 1'b1;
            end
          end
        end
      end
      default: begin
        d.tstate = UAS_IDLE;
      end
    endcase

    // Disabling the transmitter drops the frame in flight
    if (!q.sta.txen) begin
      d.tstate = UAS_IDLE;
      d.tbrk = 1'b0;
    end

    // Serial level of the frame, polarity and infrared coding on the pin
    case (d.tstate)
      UAS_START: d.traw = 1'b0;
      UAS_DATA: d.traw = !d.tbrk && d.tsh[0];
      UAS_PAR: d.traw = d.tpar;
      default: d.traw = 1'b1;
    endcase
    ir_pulse = !d.traw && (d.tcnt < `UAS_IR_PULSE);
    d.txo = (q.mode.infrared_coding_on ? ir_pulse : d.traw) ^ q.sta.txinv;
    d.txoe_n = !q.sta.txen;

    // Receiver frame sequence
    d.rprev = rx_line;
    if (tick) begin
      d.rcnt = q.rcnt + 4'h1;
    end
    case (q.rstate)
      UAS_IDLE: begin
        d.rcnt = 4'h0;
        if (!q.mode.abaud && tick && !rx_line) begin
          d.rstate = UAS_START;
        end
      end
      UAS_START: begin
        // Confirm the start bit at its middle, else treat as a glitch
        if (r_mid) begin
          d.rcnt = 4'h0;
          d.rbit = 4'h0;
          d.rperr = 1'b0;
          d.rstate = rx_line ? UAS_IDLE : UAS_DATA;
        end
      end
      UAS_DATA: begin
        if (r_end) begin
          d.rsh = {rx_line, q.rsh[8:1]};
          d.rbit = q.rbit + 4'h1;
          if (q.rbit == rx_nbits - 4'h1) begin
            d.rstate = (q.mode.par_en && !q.mode.nine) ? UAS_PAR : UAS_STOP1;
          end
        end
      end
      UAS_PAR: begin
        if (r_end) begin
          d.rperr = rx_line != par_of(q.rsh[8:1], q.mode.par_odd);
          d.rstate = UAS_STOP1;
        end
      end
      UAS_STOP1: begin
        // One stop bit is checked; a second one simply reads as idle
        if (r_end) begin
          d.rstate = UAS_IDLE;
          if (q.sta.overrun_error_flag) begin
            rf_push = 1'b0;
          end else if (q.sta.address_detect_on && q.mode.nine && !rx_word[8]) begin
            rf_push = 1'b0;
          end else if (rf_full) begin
            d.sta.overrun_error_flag = 1'b1;
          end else begin
            rf_push = 1'b1;
            if (!q.sta.rxisel[1] || (q.sta.rxisel[0] ? rf_cnt == 3'h3 : rf_cnt == 3'h2)) begin
              d.rxirq = 1'b1;
            end
          end
        end
      end
      default: begin
        d.rstate = UAS_IDLE;
      end
    endcase

    // Automatic baud: eight bit times span five falling edges of 0x55
    if (q.mode.abaud) begin
      d.abcnt = q.abcnt + 20'h00001;
      if (q.rprev && !rx_line) begin
        d.abfall = q.abfall + 3'h1;
        // Count from one so the span holds whole clocks up to the fifth fall
        if (q.abfall == 3'h0) begin
          d.abcnt = 20'h00001;
        end
        if (q.abfall == `UAS_AB_FALLS) begin
          d.brg = {3'h0, q.abcnt[19:7]} - 16'h0001;
          d.mode.abaud = 1'b0;
          d.abfall = 3'h0;
        end
      end
    end else begin
      d.abfall = 3'h0;
    end

    // Request-to-send low while the receive buffer has room
    d.rts_n = q.mode.flow && rf_full;
  end

  // ==========================================================
  // State register and outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= UAS_MAIN_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign serial_tx_pin = q.txo;
  assign serial_tx_oe_n = q.txoe_n;
  assign request_to_send_out_n = q.rts_n;
  assign baud_x16_clk = q.bclk;
  assign tx_irq = q.txirq;
  assign rx_irq = q.rxirq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_sta_read;
    reg_rd && reg_addr == `UAS_OFF_STA;
  endsequence
  sequence s_tx_load;
    tf_pop && q.sta.txisel == 2'h0;
  endsequence

  property p_txbf;
    s_sta_read |=> reg_rdata[`UAS_B_TXBF] == $past(tf_full);
  endproperty
  a_txbf: assert property (p_txbf) else $error("buffer full flag wrong");

  property p_tx_all_empty_flag;
    s_sta_read |=> reg_rdata[`UAS_B_TX_ALL_EMPTY_FLAG] == ($past(tf_empty) && $past(q.tstate) == UAS_IDLE);
  endproperty
  a_tx_all_empty_flag: assert property (p_tx_all_empty_flag) else $error("all-empty flag wrong");

  property p_txen_abort;
    !q.sta.txen |=> q.tstate == UAS_IDLE && tf_empty && serial_tx_oe_n;
  endproperty
  a_txen_abort: assert property (p_txen_abort) else $error("disable did not abort");

  property p_overrun_error_flag_sticky;
    q.sta.overrun_error_flag && !(reg_wr && reg_addr == `UAS_OFF_STA && !reg_wdata[`UAS_B_OVERRUN_ERROR_FLAG]) |=> q.sta.overrun_error_flag;
  endproperty
  a_overrun_error_flag_sticky: assert property (p_overrun_error_flag_sticky) else $error("overrun flag lost");

  property p_overrun_drop;
    q.sta.overrun_error_flag |-> !rf_push;
  endproperty
  a_overrun_drop: assert property (p_overrun_drop) else $error("push during overrun");

  property p_txirq_load;
    s_tx_load |=> tx_irq && q.tstate == UAS_START;
  endproperty
  a_txirq_load: assert property (p_txirq_load) else $error("no irq on load");

  property p_break_zero;
    q.tstate == UAS_DATA && q.tbrk |-> !q.traw;
  endproperty
  a_break_zero: assert property (p_break_zero) else $error("break bit not zero");

  property p_idle_pol;
    q.sta.txen && !q.mode.infrared_coding_on && !reg_wr |=> serial_tx_pin == (q.traw ^ $past(q.sta.txinv));
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("tx polarity wrong");

  property p_rts;
    q.mode.flow && !reg_wr |=> request_to_send_out_n == $past(rf_full);
  endproperty
  a_rts: assert property (p_rts) else $error("rts does not follow buffer");
endmodule
`default_nettype wire

//--- dv/uas_peer.sv
// Behavioural remote serial peer: drives the receive line, decodes the transmit line
`timescale 1ns/100ps
`default_nettype none
module uas_peer #(
  parameter int BIT_CLK = 16
) (
  input wire logic sys_clk,
  input wire logic tx_line,
  input wire logic rts_n,
  output var logic rx_line,
  output var logic cts_n
);
  logic [7:0] got_q[$];
  int low_run;
  int max_low;
  // Line idles high (mark), peer ready to take data
  initial begin
    rx_line = 1'b1;
    cts_n = 1'b0;
    low_run = 0;
    max_low = 0;
  end
  // One bit period on the receive line
  task automatic put_bit(input logic b);
    rx_line <= b;
    repeat (BIT_CLK) @(posedge sys_clk);
  endtask
  // Frame shaped by the mode byte; bad_par and bad_stop spoil it on purpose
  task automatic send(input logic [8:0] d, input logic [7:0] md, input logic bad_par,
      input logic bad_stop, input logic ign_rts);
    while (rts_n && !ign_rts) begin
      @(posedge sys_clk);
    end
    put_bit(1'b0);
    for (int i = 0; i < (md[0] ? 9 : 8); i++) begin
      put_bit(d[i]);
    end
    if (md[1] && !md[0]) begin
      put_bit(^d[7:0] ^ md[2] ^ bad_par);
    end
    put_bit(!bad_stop);
    if (md[3] || bad_stop) begin
      put_bit(1'b1);
    end
  endtask
  // Pause or allow the device transmitter
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask
  // Forget what was seen so far
  task automatic clear_mon();
    got_q.delete();
    max_low = 0;
  endtask
  // Longest low stretch on the transmit line, for break length
  always @(posedge sys_clk) begin
    low_run <= tx_line ? 0 : low_run + 1;
    if (low_run > max_low) begin
      max_low <= low_run;
    end
  end
  // Eight-bit decoder, sampling mid-bit after the start edge
  initial forever begin
    logic [7:0] b;
    @(negedge tx_line);
    repeat (BIT_CLK / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLK) @(posedge sys_clk);
      b[i] = tx_line;
    end
    repeat (BIT_CLK) @(posedge sys_clk);
    got_q.push_back(b);
  end
endmodule
`default_nettype wire

//--- dv/uas_serial_port_test.sv
// Self-checking bench for the serial port with a remote peer on the link
`timescale 1ns/100ps
`default_nettype none
`include "uas_cfg.svh"
module uas_serial_port_test;
  // Receive rows: mode byte, character, injected faults, expected error bits
  typedef struct packed {
    logic [7:0] mode;
    logic [8:0] data;
    logic bad_par;
    logic bad_stop;
    logic [1:0] err;
  } uas_row_s;
  localparam uas_row_s ROWS [7] = '{
    '{8'h00, 9'h0A5, 1'b0, 1'b0, 2'h0},
    '{8'h02, 9'h03C, 1'b0, 1'b0, 2'h0},
    '{8'h06, 9'h081, 1'b0, 1'b0, 2'h0},
    '{8'h06, 9'h07E, 1'b1, 1'b0, 2'h2},
    '{8'h00, 9'h0FF, 1'b0, 1'b1, 2'h1},
    '{8'h01, 9'h1C3, 1'b0, 1'b0, 2'h0},
    '{8'h08, 9'h05A, 1'b0, 1'b0, 2'h0}
  };
  logic sys_clk;
  logic rst;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic tx_pin;
  logic tx_oe_n;
  logic rx_line;
  logic cts_n;
  logic rts_n;
  logic x16_clk;
  logic tx_irq;
  logic rx_irq;
  wire logic tx_wire;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_txirq = 0;
  int n_rxirq = 0;
  int n_x16 = 0;
  // Released transmit line is pulled up
  assign tx_wire = tx_oe_n ? 1'b1 : tx_pin;
  uas_serial_port uas_serial_port_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_tx_pin(tx_pin),
    .serial_tx_oe_n(tx_oe_n), .serial_rx_pin(rx_line), .clear_to_send_in_n(cts_n),
    .request_to_send_out_n(rts_n), .baud_x16_clk(x16_clk), .tx_irq(tx_irq), .rx_irq(rx_irq)
  );
  uas_peer uas_peer_inst (
    .sys_clk(sys_clk), .tx_line(tx_wire), .rts_n(rts_n), .rx_line(rx_line), .cts_n(cts_n)
  );
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Interrupt pulse and 16x clock counters
  always @(posedge sys_clk) begin
    if (tx_irq === 1'b1) n_txirq++;
    if (rx_irq === 1'b1) n_rxirq++;
  end
  always @(posedge x16_clk) n_x16++;
  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic expect_reg(input string nm, input logic [3:0] a, input logic [15:0] m,
      input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(nm, e, reg_rdata & m);
  endtask
  task automatic final_report();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 4600 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    expect_reg("sta_reset", `UAS_OFF_STA, 16'hFFFF, 16'h0110);
    expect_reg("unmapped", 4'hF, 16'hFFFF, 16'h0000);
    chk("oe_n_reset", 16'h0001, {15'h0, tx_oe_n});
    // Receive table: formats, parity and framing faults
    foreach (ROWS[i]) begin
      wr(`UAS_OFF_MODE, {8'h00, ROWS[i].mode});
      uas_peer_inst.send(ROWS[i].data, ROWS[i].mode, ROWS[i].bad_par, ROWS[i].bad_stop, 1'b0);
      repeat (8) @(posedge sys_clk);
      expect_reg("rx_sta", `UAS_OFF_STA, 16'h000D, {12'h0, ROWS[i].err, 2'h1});
      expect_reg("rx_data", `UAS_OFF_RXD, 16'h01FF, {7'h0, ROWS[i].data});
      expect_reg("rx_empty", `UAS_OFF_STA, 16'h0001, 16'h0000);
    end
    // Transmit queue held by clear-to-send, then released
    n_txirq = 0;
    wr(`UAS_OFF_MODE, 16'h0020);
    uas_peer_inst.set_cts(1'b1);
    wr(`UAS_OFF_STA, 16'h0400);
    @(posedge sys_clk);
    chk("oe_n_on", 16'h0000, {15'h0, tx_oe_n});
    for (int i = 1; i <= 5; i++) begin
      reg_addr <= `UAS_OFF_TXD;
      reg_wdata <= 16'(i * 16'h0011);
      reg_wr <= 1'b1;
      @(posedge sys_clk);
    end
    reg_wr <= 1'b0;
    repeat (40) @(posedge sys_clk);
    expect_reg("tx_full", `UAS_OFF_STA, 16'h0300, 16'h0200);
    chk("cts_hold", 16'h0000, 16'(uas_peer_inst.got_q.size()));
    uas_peer_inst.set_cts(1'b0);
    repeat (800) @(posedge sys_clk);
    chk("tx_count", 16'h0004, 16'(uas_peer_inst.got_q.size()));
    for (int i = 0; i < 4; i++) begin
      chk("tx_byte", 16'((i + 1) * 16'h0011), {8'h0, uas_peer_inst.got_q[i]});
    end
    chk("tx_irq_loads", 16'h0004, 16'(n_txirq));
    expect_reg("tx_done", `UAS_OFF_STA, 16'h0300, 16'h0100);
    // Receive buffer filled to overrun under flow control
    n_rxirq = 0;
    wr(`UAS_OFF_STA, 16'h04C0);
    for (int i = 0; i < 5; i++) begin
      uas_peer_inst.send(9'(16'h00A0 + i), 8'h20, 1'b0, 1'b0, i == 4);
      repeat (8) @(posedge sys_clk);
    end
    chk("rts_full", 16'h0001, {15'h0, rts_n});
    chk("rx_irq_four", 16'h0001, 16'(n_rxirq));
    expect_reg("overrun", `UAS_OFF_STA, 16'h0003, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      expect_reg("rx_fifo", `UAS_OFF_RXD, 16'h01FF, 16'(16'h00A0 + i));
    end
    expect_reg("ovr_sticky", `UAS_OFF_STA, 16'h0003, 16'h0002);
    wr(`UAS_OFF_STA, 16'h04C0);
    expect_reg("ovr_clear", `UAS_OFF_STA, 16'h0002, 16'h0000);
    chk("rts_room", 16'h0000, {15'h0, rts_n});
    // Break: start, twelve zeros, stop, then the request clears itself
    wr(`UAS_OFF_MODE, 16'h0000);
    uas_peer_inst.clear_mon();
    wr(`UAS_OFF_STA, 16'h0C00);
    repeat (300) @(posedge sys_clk);
    chk("brk_len", 16'h0001, {15'h0, uas_peer_inst.max_low inside {[200:215]}});
    expect_reg("brk_clr", `UAS_OFF_STA, 16'h0800, 16'h0000);
    // Loopback
    wr(`UAS_OFF_MODE, 16'h0010);
    wr(`UAS_OFF_TXD, 16'h0096);
    repeat (250) @(posedge sys_clk);
    expect_reg("loop_data", `UAS_OFF_RXD, 16'h01FF, 16'h0096);
    // Address detect: a nine-bit character with its ninth bit clear is dropped
    wr(`UAS_OFF_MODE, 16'h0011);
    wr(`UAS_OFF_STA, 16'h0420);
    wr(`UAS_OFF_TXD, 16'h00A5);
    wr(`UAS_OFF_TXD, 16'h01A5);
    repeat (400) @(posedge sys_clk);
    expect_reg("adr_kept", `UAS_OFF_RXD, 16'h01FF, 16'h01A5);
    expect_reg("adr_only", `UAS_OFF_STA, 16'h0001, 16'h0000);
    // Idle polarity, plain and with infrared coding, then disable
    wr(`UAS_OFF_MODE, 16'h0000);
    wr(`UAS_OFF_STA, 16'h4400);
    @(posedge sys_clk);
    chk("idle_inv", 16'h0000, {15'h0, tx_pin});
    wr(`UAS_OFF_MODE, 16'h0080);
    @(posedge sys_clk);
    chk("idle_ir_inv", 16'h0001, {15'h0, tx_pin});
    wr(`UAS_OFF_STA, 16'h0000);
    wr(`UAS_OFF_TXD, 16'h0033);
    chk("oe_n_off", 16'h0001, {15'h0, tx_oe_n});
    expect_reg("tx_off", `UAS_OFF_STA, 16'h0300, 16'h0100);
    // Automatic baud from a 0x55 sync character at sixteen clocks a bit
    wr(`UAS_OFF_BRG, 16'h0005);
    wr(`UAS_OFF_MODE, 16'h0040);
    uas_peer_inst.send(9'h055, 8'h00, 1'b0, 1'b0, 1'b0);
    expect_reg("abaud_brg", `UAS_OFF_BRG, 16'hFFFF, 16'h0000);
    expect_reg("abaud_off", `UAS_OFF_MODE, 16'h0040, 16'h0000);
    // Prescaler of 3 gives a tick, and a 16x clock edge, every 4 clocks
    wr(`UAS_OFF_BRG, 16'h0003);
    n_x16 = 0;
    repeat (400) @(posedge sys_clk);
    chk("x16_rate", 16'h0001, {15'h0, n_x16 inside {[99:101]}});
    final_report();
  end
endmodule
`default_nettype wire
